// ### logic/sup_pkg.sv
package sup_pkg;
  // Register offsets, byte wide data
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_OPT1 = 8'h01;
  localparam logic [7:0] OFF_OPT2 = 8'h02;
  localparam logic [7:0] OFF_PM1 = 8'h03;
  localparam logic [7:0] OFF_PM2 = 8'h04;
  localparam logic [7:0] OFF_WAKE = 8'h05;
  // Field positions
  localparam int ST_POR = 7;
  localparam int ST_WD = 5;
  localparam int ST_LV = 1;
  localparam int O1_EN = 7;
  localparam int O1_LONG = 6;
  localparam int O2_CLKS = 7;
  localparam int P1_FLAG = 7;
  localparam int P1_ACK = 6;
  localparam int P1_IE = 5;
  localparam int P1_RE = 4;
  localparam int P1_SE = 3;
  localparam int P1_DE = 2;
  localparam int P1_BG = 0;
  localparam int P2_FLAG = 7;
  localparam int P2_ACK = 6;
  localparam int P2_DET = 5;
  localparam int P2_WARN = 4;
  localparam int WK_FLAG = 7;
  localparam int WK_ACK = 6;
  localparam int WK_CLKS = 5;
  localparam int WK_IE = 4;
  // Reset values
  localparam logic [7:0] RST_OPT1 = 8'hc0;
  localparam logic [7:0] RST_OPT2 = 8'h00;
  localparam logic [7:0] RST_PM1 = 8'h1c;
  localparam logic [7:0] RST_PM2 = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_HZ = 32_000;
  localparam int FAST_DIV = CLK_HZ / SLOW_HZ;
  localparam int MS_HZ = 1_000;
  localparam int MS_DIV = CLK_HZ / MS_HZ;
  localparam int WD_W = 18;
  localparam logic [17:0] WD_OVF_32S = 18'h00400;
  localparam logic [17:0] WD_OVF_32L = 18'h02000;
  localparam logic [17:0] WD_OVF_BUSS = 18'h02000;
  localparam logic [17:0] WD_OVF_BUSL = 18'h3ffff;
  localparam int WK_W = 11;
  localparam logic [10:0] WK_PER [8] = '{11'h000, 11'h008,
    11'h020, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400};
endpackage

// ### logic/wake_if.sv
`timescale 1ns/1ns
`default_nettype none
interface wake_if;
  logic tick;
  logic [2:0] sel;
  logic ack;
  logic flag;
  modport ctl (output tick, output sel, output ack, input flag);
  modport tmr (input tick, input sel, input ack, output flag);
endinterface
`default_nettype wire

// ### logic/tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module tick_div import sup_pkg::*; #(
  parameter int DIV = FAST_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // One-cycle enable every DIV cycles
  output logic tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_s;
  div_s st_r;
  div_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = (st_r.cnt == LAST);
    st_nxt.cnt = st_nxt.tick ? '0 : st_r.cnt + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule
`default_nettype wire

// ### logic/wakeup_timer.sv
`timescale 1ns/1ns
`default_nettype none
module wakeup_timer import sup_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control side
  wake_if.tmr wk
);
  typedef struct packed {
    logic [WK_W-1:0] cnt;
    logic flag;
  } wk_s;
  wk_s st_r;
  wk_s st_nxt;
  logic hit;

  always_comb begin
    st_nxt = st_r;
    hit = 1'b0;
    if (wk.sel == 3'h0) begin
      st_nxt.cnt = '0;
    end else if (wk.tick) begin
      hit = (st_r.cnt == WK_PER[wk.sel] - 1'b1);
      st_nxt.cnt = hit ? '0 : st_r.cnt + 1'b1;
    end
    // Set beats acknowledge
    if (wk.ack) begin
      st_nxt.flag = 1'b0;
    end
    if (hit) begin
      st_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wk.flag = st_r.flag;
endmodule
`default_nettype wire

// ### logic/sys_supervisor.sv
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module sys_supervisor import sup_pkg::*; #(
  parameter int MS_DIVIDE = MS_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // System state
  input wire logic por_active,
  input wire logic bdm_halt,
  input wire logic stop_mode,
  input wire logic stop_deep,
  // Supply comparators, high when supply is below the trip
  input wire logic below_det_low,
  input wire logic below_det_high,
  input wire logic below_warn_low,
  input wire logic below_warn_high,
  // Outputs
  output logic sys_reset_req,
  output logic lowv_irq,
  output logic wakeup_irq,
  output logic bandgap_buffer_enable
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [WD_W-1:0] wd_cnt;
    logic wd_fire;
    logic wd_cause;
    logic lv_cause;
    logic in_rst;
    logic [7:0] status;
    logic wd_en;
    logic wd_long;
    logic wd_clk_bus;
    logic opt1_lock;
    logic opt2_lock;
    logic pm1_lock;
    logic lv_flag;
    logic lv_ie;
    logic lv_re;
    logic lv_se;
    logic lv_de;
    logic bg_en;
    logic warn_flag;
    logic det_trip;
    logic warn_trip;
    logic below_q;
    logic stop_q;
    logic wk_clk_fast;
    logic wk_ie;
    logic [2:0] wk_sel;
  } sup_s;

  sup_s st_r;
  sup_s st_nxt;
  sup_s st_rst;
  logic tick_fast;
  logic tick_ms;
  logic wr_status;
  logic wr_opt1;
  logic wr_opt2;
  logic wr_pm1;
  logic wr_pm2;
  logic wr_wake;
  logic wd_step;
  logic [WD_W-1:0] wd_ovf;
  logic below_det;
  logic lv_active;
  logic lv_hold;
  logic [7:0] rd_mux;

  wake_if wk ();

  tick_div #(.DIV(FAST_DIV)) u_div_fast (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick_fast)
  );

  tick_div #(.DIV(MS_DIVIDE)) u_div_ms (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick_ms)
  );

  wakeup_timer u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .wk(wk.tmr)
  );

  assign wr_status = wr_en && (addr == OFF_STATUS);
  assign wr_opt1 = wr_en && (addr == OFF_OPT1);
  assign wr_opt2 = wr_en && (addr == OFF_OPT2);
  assign wr_pm1 = wr_en && (addr == OFF_PM1);
  assign wr_pm2 = wr_en && (addr == OFF_PM2);
  assign wr_wake = wr_en && (addr == OFF_WAKE);

  // Deep stop only keeps the 1 kHz tick alive
  assign wk.tick = stop_deep ? (tick_ms && !st_r.wk_clk_fast)
                 : (st_r.wk_clk_fast ? tick_fast : tick_ms);
  assign wk.sel = st_r.wk_sel;
  assign wk.ack = wr_wake && wdata[WK_ACK];

  always_comb begin
    case ({st_r.wd_clk_bus, st_r.wd_long})
      2'b00: wd_ovf = WD_OVF_32S;
      2'b01: wd_ovf = WD_OVF_32L;
      2'b10: wd_ovf = WD_OVF_BUSS;
      // 2^18 does not fit 18 bits; overflow value is all ones, so the terminal count is all ones minus 1
      2'b11: wd_ovf = WD_OVF_BUSL;
      default: wd_ovf = WD_OVF_32L;
    endcase
  end

  assign wd_step = st_r.wd_en && !bdm_halt
                && !stop_mode
                && (st_r.wd_clk_bus || tick_fast);
  assign below_det = st_r.det_trip ? below_det_high : below_det_low;
  assign lv_active = st_r.lv_de && (!stop_mode || st_r.lv_se);
  assign lv_hold = st_r.lv_de && st_r.lv_re
                && (st_r.lv_flag || below_det);

  always_comb begin
    case (addr)
      OFF_STATUS: rd_mux = st_r.status;
      OFF_OPT1: rd_mux = {st_r.wd_en, st_r.wd_long, 6'h00};
      OFF_OPT2: rd_mux = {st_r.wd_clk_bus, 7'h00};
      OFF_PM1: rd_mux = {st_r.lv_flag, 1'b0, st_r.lv_ie, st_r.lv_re,
                         st_r.lv_se, st_r.lv_de, 1'b0, st_r.bg_en};
      OFF_PM2: rd_mux = {st_r.warn_flag, 1'b0, st_r.det_trip,
                         st_r.warn_trip, 4'h0};
      OFF_WAKE: rd_mux = {wk.flag, 1'b0, st_r.wk_clk_fast, st_r.wk_ie,
                          1'b0, st_r.wk_sel};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.in_rst = 1'b0;
    st_nxt.wd_fire = 1'b0;
    st_nxt.below_q = below_det;
    st_nxt.stop_q = stop_mode;
    st_nxt.rdata = rd_en ? rd_mux : 8'h00;
    // Watchdog
    if (wd_step) begin
      if (st_r.wd_cnt == wd_ovf - 1'b1) begin
        st_nxt.wd_fire = 1'b1;
        st_nxt.wd_cause = 1'b1;
        st_nxt.wd_cnt = '0;
      end else begin
        st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
      end
    end
    if (stop_mode && !st_r.wd_clk_bus) begin
      st_nxt.wd_cnt = '0;
    end
    if (wr_status || (wr_opt1 && !st_r.opt1_lock)
        || (wr_opt2 && !st_r.opt2_lock)) begin
      st_nxt.wd_cnt = '0;
    end
    // Write-once option registers
    if (wr_opt1 && !st_r.opt1_lock) begin
      st_nxt.opt1_lock = 1'b1;
      st_nxt.wd_en = wdata[O1_EN];
      st_nxt.wd_long = wdata[O1_LONG];
    end
    if (wr_opt2 && !st_r.opt2_lock) begin
      st_nxt.opt2_lock = 1'b1;
      st_nxt.wd_clk_bus = wdata[O2_CLKS];
    end
    // Low-voltage control
    if (wr_pm1) begin
      st_nxt.lv_ie = wdata[P1_IE];
      st_nxt.lv_se = wdata[P1_SE];
      st_nxt.bg_en = wdata[P1_BG];
      if (!st_r.pm1_lock) begin
        st_nxt.pm1_lock = 1'b1;
        st_nxt.lv_re = wdata[P1_RE];
        st_nxt.lv_de = wdata[P1_DE];
      end
      if (wdata[P1_ACK]) begin
        st_nxt.lv_flag = 1'b0;
      end
    end
    if (lv_active && below_det && !st_r.below_q) begin
      st_nxt.lv_flag = 1'b1;
    end
    if (lv_hold) begin
      st_nxt.lv_cause = 1'b1;
    end
    // Warning flag, no interrupt path
    if (wr_pm2) begin
      st_nxt.det_trip = wdata[P2_DET];
      st_nxt.warn_trip = wdata[P2_WARN];
      if (wdata[P2_ACK]) begin
        st_nxt.warn_flag = 1'b0;
      end
    end
    if (st_r.warn_trip ? below_warn_high : below_warn_low) begin
      st_nxt.warn_flag = 1'b1;
    end
    // Periodic wakeup control
    if (wr_wake) begin
      st_nxt.wk_clk_fast = wdata[WK_CLKS];
      st_nxt.wk_ie = wdata[WK_IE];
      st_nxt.wk_sel = wdata[2:0];
    end
  end

  // Reset image; status gathers the cause across the reset
  always_comb begin
    st_rst = '0;
    st_rst.in_rst = 1'b1;
    st_rst.wd_en = RST_OPT1[O1_EN];
    st_rst.wd_long = RST_OPT1[O1_LONG];
    st_rst.wd_clk_bus = RST_OPT2[O2_CLKS];
    st_rst.lv_re = RST_PM1[P1_RE];
    st_rst.lv_se = RST_PM1[P1_SE];
    st_rst.lv_de = RST_PM1[P1_DE];
    st_rst.det_trip = RST_PM2[P2_DET];
    st_rst.warn_trip = RST_PM2[P2_WARN];
    st_rst.wk_ie = RST_WAKE[WK_IE];
    // Power-on starts a fresh record, so no stale or unknown bits survive
    st_rst.status = (st_r.in_rst && !por_active) ? st_r.status : 8'h00;
    st_rst.status[ST_POR] = st_rst.status[ST_POR] | por_active;
    st_rst.status[ST_WD] = st_rst.status[ST_WD] | st_r.wd_cause;
    st_rst.status[ST_LV] = st_rst.status[ST_LV] | por_active
                         | st_r.lv_cause;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= st_rst;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign sys_reset_req = st_r.wd_fire || lv_hold;
  assign lowv_irq = st_r.lv_flag && st_r.lv_ie && st_r.lv_de
                 && !st_r.lv_re;
  assign wakeup_irq = wk.flag && st_r.wk_ie && (st_r.wk_sel != 3'h0);
  assign bandgap_buffer_enable = st_r.bg_en;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_WD_EN_AFTER_RST: assert property (
    $rose(rst_n) |-> st_r.wd_en && st_r.wd_long && !st_r.wd_clk_bus)
    else $error("watchdog defaults wrong after reset");
  AST_WD_FIRE: assert property (
    wd_step && st_r.wd_cnt == wd_ovf - 1'b1 && !stop_mode
    |=> sys_reset_req && st_r.wd_cnt == '0)
    else $error("watchdog overflow did not request reset");
  AST_WD_PULSE: assert property (
    st_r.wd_fire |=> !st_r.wd_fire)
    else $error("watchdog reset pulse longer than one cycle");
  AST_WD_SERVICE: assert property (
    wr_status |=> st_r.wd_cnt == '0 && $stable(st_r.status))
    else $error("service write did not clear watchdog");
  AST_OPT_ONCE: assert property (
    st_r.opt1_lock && wr_opt1 |=> $stable(st_r.wd_en)
    && $stable(st_r.wd_long))
    else $error("locked option register changed");
  AST_WD_DEBUG_HOLD: assert property (
    bdm_halt && !stop_mode && !wr_en |=> $stable(st_r.wd_cnt))
    else $error("watchdog moved in debug halt");
  AST_WD_STOP_BUS: assert property (
    stop_mode && st_r.wd_clk_bus && !wr_en |=> $stable(st_r.wd_cnt))
    else $error("bus-clock watchdog moved in stop");
  AST_WD_STOP_SLOW: assert property (
    stop_mode && !st_r.wd_clk_bus |=> st_r.wd_cnt == '0)
    else $error("slow watchdog not cleared in stop");
  AST_WD_SLOW_RATE: assert property (
    !st_r.wd_clk_bus && !tick_fast && !wr_en && !stop_mode
    |=> $stable(st_r.wd_cnt))
    else $error("slow watchdog counted without tick");
  AST_LV_IRQ: assert property (
    st_r.lv_de && st_r.lv_ie && !st_r.lv_re && !wr_pm1
    && (!stop_mode || st_r.lv_se) && $rose(below_det)
    |=> lowv_irq)
    else $error("low-voltage event raised no interrupt");
  AST_LV_HOLD: assert property (
    st_r.lv_de && st_r.lv_re && below_det |-> sys_reset_req)
    else $error("low-voltage reset released early");
  AST_POR_STATUS: assert property (
    $rose(rst_n) && $past(por_active)
    |-> st_r.status[ST_POR] && st_r.status[ST_LV])
    else $error("power-on status bits missing");
  AST_WAKE_DEEP: assert property (
    stop_deep && st_r.wk_clk_fast |-> !wk.tick)
    else $error("fast tick reached wakeup timer in deep stop");

  COV_WD_FIRE: cover property (st_r.wd_fire);
  COV_LV_IRQ: cover property (lowv_irq);
  COV_WAKE_IRQ: cover property (wakeup_irq);
  COV_SERVICE: cover property (wr_status ##1 wr_opt1);
endmodule
`default_nettype wire

// ### bench/sys_supervisor_test.sv
`timescale 1ns/1ns
`default_nettype none
module sys_supervisor_test import sup_pkg::*;;
  // Short 1 kHz divider keeps wakeup periods within a brief run
  localparam int MSD = 40;
  localparam int NBUS = 8192;
  // Clock, reset and register port
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  // System state and supply comparators
  logic por_active;
  logic bdm_halt;
  logic stop_mode;
  logic stop_deep;
  logic below_det_low;
  logic below_det_high;
  logic below_warn_low;
  logic below_warn_high;
  // Outputs
  logic sys_reset_req;
  logic lowv_irq;
  logic wakeup_irq;
  logic bandgap_buffer_enable;
  int bad_count;
  int num_checks;
  logic [7:0] v;
  int tick_tab [4] = '{8, 32, 64, 128};

  sys_supervisor #(.MS_DIVIDE(MSD)) uut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .por_active(por_active),
    .bdm_halt(bdm_halt), .stop_mode(stop_mode), .stop_deep(stop_deep),
    .below_det_low(below_det_low), .below_det_high(below_det_high),
    .below_warn_low(below_warn_low), .below_warn_high(below_warn_high),
    .sys_reset_req(sys_reset_req), .lowv_irq(lowv_irq),
    .wakeup_irq(wakeup_irq), .bandgap_buffer_enable(bandgap_buffer_enable)
  );

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    por_active = 1'b1;
    bdm_halt = 1'b0;
    stop_mode = 1'b0;
    stop_deep = 1'b0;
    below_det_low = 1'b0;
    below_det_high = 1'b0;
    below_warn_low = 1'b0;
    below_warn_high = 1'b0;
    bad_count = 0;
    num_checks = 0;
  end

  always #5 clk = ~clk;

  task automatic end_of_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check8(d, exp);
  endtask

  // Result code: 1 event inside window, 2 too early, 0 never seen
  task automatic watch(input bit irq, input int quiet, input int win,
                       input logic [7:0] exp);
    int n;
    logic s;
    n = 0;
    s = 1'b0;
    while (n < quiet + win && s !== 1'b1) begin
      @(posedge clk);
      #1;
      s = irq ? wakeup_irq : sys_reset_req;
      n++;
    end
    check8(s !== 1'b1 ? 8'h00 : (n > quiet ? 8'h01 : 8'h02), exp);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    por_active <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    por_active <= 1'b0;
    rchk(OFF_STATUS, 8'h82);
    rchk(OFF_OPT1, RST_OPT1);
    step(1);
    check8(rdata, 8'h00);
    rchk(OFF_OPT2, RST_OPT2);
    rchk(OFF_PM1, RST_PM1);
    rchk(OFF_PM2, RST_PM2);
    rchk(OFF_WAKE, RST_WAKE);
    rchk(8'h3f, 8'h00);
    // Low-voltage reset holds through reset until supply recovers
    @(posedge clk);
    below_det_low <= 1'b1;
    step(2);
    check1(sys_reset_req, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    step(4);
    check1(sys_reset_req, 1'b1);
    @(posedge clk);
    below_det_low <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    step(2);
    check1(sys_reset_req, 1'b0);
    rd(OFF_STATUS, v);
    check1(v[ST_LV], 1'b1);
    // Bus clock, short timeout, locked by first writes
    wr(OFF_OPT2, 8'h80);
    wr(OFF_OPT1, 8'h80);
    wr(OFF_OPT1, 8'h00);
    rchk(OFF_OPT1, 8'h80);
    rchk(OFF_OPT2, 8'h80);
    rd(OFF_STATUS, v);
    wr(OFF_STATUS, 8'hff);
    rchk(OFF_STATUS, v);
    watch(1'b0, 6000, 0, 8'h00);
    wr(OFF_STATUS, 8'h00);
    watch(1'b0, NBUS - 60, 120, 8'h01);
    // Debug halt freezes the count
    wr(OFF_STATUS, 8'h00);
    bdm_halt <= 1'b1;
    watch(1'b0, 9000, 0, 8'h00);
    @(posedge clk);
    bdm_halt <= 1'b0;
    watch(1'b0, NBUS - 60, 120, 8'h01);
    // Stop with bus clock freezes, then resumes from the held count
    wr(OFF_STATUS, 8'h00);
    watch(1'b0, 5000, 0, 8'h00);
    stop_mode <= 1'b1;
    watch(1'b0, 5000, 0, 8'h00);
    @(posedge clk);
    stop_mode <= 1'b0;
    watch(1'b0, NBUS - 5000 - 60, 120, 8'h01);
    do_reset;
    rd(OFF_STATUS, v);
    check1(v[ST_WD], 1'b1);
    rchk(OFF_OPT1, RST_OPT1);
    // Low-voltage interrupt path
    wr(OFF_PM1, 8'h25);
    step(1);
    check1(bandgap_buffer_enable, 1'b1);
    @(posedge clk);
    below_det_low <= 1'b1;
    step(2);
    check1(lowv_irq, 1'b1);
    check1(sys_reset_req, 1'b0);
    rchk(OFF_PM1, 8'ha5);
    below_det_low <= 1'b0;
    wr(OFF_PM1, 8'h75);
    step(1);
    check1(lowv_irq, 1'b0);
    rchk(OFF_PM1, 8'h25);
    wr(OFF_PM1, 8'h05);
    below_det_low <= 1'b1;
    step(2);
    check1(lowv_irq, 1'b0);
    below_det_low <= 1'b0;
    wr(OFF_PM1, 8'h45);
    // Stop enable decides whether detection runs in stop
    wr(OFF_PM1, 8'h21);
    stop_mode <= 1'b1;
    below_det_low <= 1'b1;
    step(2);
    check1(lowv_irq, 1'b0);
    below_det_low <= 1'b0;
    wr(OFF_PM1, 8'h29);
    below_det_low <= 1'b1;
    step(2);
    check1(lowv_irq, 1'b1);
    stop_mode <= 1'b0;
    below_det_low <= 1'b0;
    wr(OFF_PM1, 8'h61);
    // High detect trip through the select bit
    wr(OFF_PM2, 8'h20);
    below_det_high <= 1'b1;
    step(2);
    check1(lowv_irq, 1'b1);
    below_det_high <= 1'b0;
    wr(OFF_PM1, 8'h61);
    // Warning flag follows only the selected trip
    wr(OFF_PM2, 8'h00);
    below_warn_high <= 1'b1;
    rchk(OFF_PM2, 8'h00);
    below_warn_low <= 1'b1;
    rchk(OFF_PM2, 8'h80);
    below_warn_low <= 1'b0;
    wr(OFF_PM2, 8'h50);
    rchk(OFF_PM2, 8'h90);
    below_warn_high <= 1'b0;
    wr(OFF_PM2, 8'h50);
    rchk(OFF_PM2, 8'h10);
    // Wakeup periods on the 1 kHz tick, in deep stop
    stop_mode <= 1'b1;
    stop_deep <= 1'b1;
    for (int s = 1; s <= 4; s++) begin
      wr(OFF_WAKE, 8'h50 | 8'(s));
      watch(1'b1, 0, (tick_tab[s-1] + 2) * MSD, 8'h01);
      wr(OFF_WAKE, 8'h50 | 8'(s));
      watch(1'b1, (tick_tab[s-1] - 1) * MSD, 2 * MSD, 8'h01);
    end
    wr(OFF_WAKE, 8'h10);
    step(1);
    check1(wakeup_irq, 1'b0);
    watch(1'b1, 20 * MSD, 0, 8'h00);
    stop_mode <= 1'b0;
    stop_deep <= 1'b0;
    // 32 kHz tick as wakeup source, then parked by deep stop
    wr(OFF_WAKE, 8'h71);
    watch(1'b1, 6 * FAST_DIV, 3 * FAST_DIV, 8'h01);
    stop_mode <= 1'b1;
    stop_deep <= 1'b1;
    wr(OFF_WAKE, 8'h71);
    watch(1'b1, 2 * FAST_DIV, 0, 8'h00);
    stop_mode <= 1'b0;
    stop_deep <= 1'b0;
    end_of_test;
  end

  initial begin
    #2_000_000;
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
